// ===== core/ata_cmd_pkg.sv
// Shared constants for the flush and track format command path.
package ata_cmd_pkg;
  // Command codes.
  localparam logic [7:0] OP_FLUSH_EXT    = 8'hEA;
  localparam logic [7:0] OP_FORMAT_TRACK = 8'h50;
  // Task file register selects.
  localparam logic [2:0] TF_DATA     = 3'h0;
  localparam logic [2:0] TF_SECTOR   = 3'h3;
  localparam logic [2:0] TF_CYL_LO   = 3'h4;
  localparam logic [2:0] TF_CYL_HI   = 3'h5;
  localparam logic [2:0] TF_DEV_HEAD = 3'h6;
  localparam logic [2:0] TF_COMMAND  = 3'h7;
  // Status register bit positions.
  localparam int ST_OCCUPIED = 7;
  localparam int ST_READY    = 6;
  localparam int ST_SETTLED  = 4;
  localparam int ST_DRQ      = 3;
  localparam int ST_ERR      = 0;
  // Error register bit positions.
  localparam int ER_NOT_FOUND = 4;
  localparam int ER_REJECTED  = 2;
  // Drive and head select fields.
  localparam int DH_LBA_MODE = 6;
  // Reset values.
  localparam logic [7:0] DEV_HEAD_RESET = 8'hA0;
  localparam logic [7:0] STATUS_RESET   = 8'h50;
  // Geometry and transfer defaults.
  localparam int SECTORS_PER_TRACK = 63;
  localparam int HEAD_COUNT        = 16;
  localparam int CYL_COUNT         = 16383;
  localparam int TOTAL_LBA         = 16514064;
  localparam int TABLE_BYTES       = 512;
  // Host register offsets on APB.
  localparam logic [7:0] REG_CMD        = 8'h00;
  localparam logic [7:0] REG_ADDR       = 8'h04;
  localparam logic [7:0] REG_RESULT     = 8'h08;
  localparam logic [7:0] REG_RET_ADDR   = 8'h0C;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h14;
  // Host register fields.
  localparam int ADDR_LBA_BIT = 28;
  localparam int RES_BUSY_BIT = 16;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_ERROR    = 1;
endpackage : ata_cmd_pkg

// ===== core/ata_taskfile_if.sv
// Task file connection between the host controller and the drive.
interface ata_taskfile_if;
  logic       wr;
  logic [2:0] sel;
  logic [7:0] wdata;
  logic [7:0] status;
  logic [7:0] error;
  logic [7:0] sector;
  logic [7:0] cyl_lo;
  logic [7:0] cyl_hi;
  logic [7:0] dev_head;

  modport device (
    input  wr, sel, wdata,
    output status, error, sector, cyl_lo, cyl_hi, dev_head
  );
  modport host (
    output wr, sel, wdata,
    input  status, error, sector, cyl_lo, cyl_hi, dev_head
  );
endinterface : ata_taskfile_if

// ===== core/ata_cmd_device.sv
// Drive side command interpreter for cache flush and track format.
// Overview of operation
// R1: Code EAh starts flushing the write cache.
// R2: Flush completes only once cache is committed.
// R3: Code 50h formats exactly one logical track.
// R4: Every good sector of the track becomes zero.
// R5: No read-back check after the zero fill.
// R6: Format table accepted, descriptors ignored entirely.
// R7: Track layout fixed: 1:1, relative block addressing.
// R8: Cylinder/head mode: cylinder registers, head nibble.
// R9: Block mode: 28-bit address across four registers.
// R10: Block mode formats the track holding address.
// R11: Block mode reports current address on completion.
// R12: Out of range block address is rejected.
// R13: Any error flag sets summary, clears occupied.
module ata_cmd_device
  import ata_cmd_pkg::*;
#(
  parameter int SPT      = SECTORS_PER_TRACK,
  parameter int HEADS    = HEAD_COUNT,
  parameter int CYLS     = CYL_COUNT,
  parameter int MAX_LBA  = TOTAL_LBA,
  parameter int TBL_LEN  = TABLE_BYTES
)
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // Task file
  ata_taskfile_if.device   tf,
  // Write cache
  output logic             cache_flush_out,
  input  wire logic        cache_clean_in,
  // Media
  output logic             media_write_out,
  output logic [27:0]      media_lba_out,
  input  wire logic        sector_good_in,
  input  wire logic        media_ack_in
);

  if (SPT < 1 || SPT > 255 || HEADS < 1 || HEADS > 16 || TBL_LEN < 1 ||
      TBL_LEN > 65535 || CYLS < 1 || CYLS > 65536 || MAX_LBA < 1 ||
      MAX_LBA > 268435456)
  begin : g_check
    $error("ata_cmd_device: unsupported geometry parameters");
  end

  typedef enum logic [5:0] {
    S_IDLE   = 6'b000001,
    S_TABLE  = 6'b000010,
    S_FLUSH  = 6'b000100,
    S_FORMAT = 6'b001000,
    S_WRITE  = 6'b010000,
    S_DONE   = 6'b100000
  } dev_state_t;

  dev_state_t  state;
  logic [15:0] table_cnt;
  logic [7:0]  sec_idx;
  logic        rejected;
  logic        not_found;
  logic        cmd_take;
  logic        data_wr;
  logic        lba_mode;
  logic [27:0] lba_req;
  logic [15:0] cyl;
  logic [3:0]  head;
  logic        range_bad;
  logic        chs_bad;
  logic [27:0] track_base;
  logic [31:0] chs_lba;

  // Writes to the command register are ignored while occupied.
  assign cmd_take = tf.wr && (tf.sel == TF_COMMAND) &&
                    !tf.status[ST_OCCUPIED];
  assign data_wr  = tf.wr && (tf.sel == TF_DATA) && (state == S_TABLE);

  assign lba_mode = tf.dev_head[DH_LBA_MODE];
  assign lba_req  = {tf.dev_head[3:0], tf.cyl_hi, tf.cyl_lo,
                     tf.sector}; // [R9]
  assign cyl      = {tf.cyl_hi, tf.cyl_lo}; // [R8]
  assign head     = tf.dev_head[3:0]; // [R8]
  assign chs_lba  = (32'(cyl) * 32'(HEADS) + 32'(head)) * 32'(SPT);
  assign chs_bad  = (32'(cyl) >= 32'(CYLS)) || (32'(head) >= 32'(HEADS));
  assign range_bad = lba_mode && (32'(lba_req) >= 32'(MAX_LBA)); // [R12]

  // Block addresses map to a track by dropping the sector offset, so
  // any address on the track selects the same track.
  always_comb
  begin
    if (lba_mode)
    begin
      track_base = lba_req - 28'(32'(lba_req) % 32'(SPT)); // [R10]
    end
    else
    begin
      track_base = chs_lba[27:0]; // [R8]
    end
  end

  // Command sequencing and media access.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state           <= S_IDLE;
      table_cnt       <= '0;
      sec_idx         <= '0;
      rejected        <= 1'b0;
      not_found       <= 1'b0;
      cache_flush_out <= 1'b0;
      media_write_out <= 1'b0;
      media_lba_out   <= '0;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (cmd_take)
          begin
            rejected  <= 1'b0;
            not_found <= 1'b0;
            table_cnt <= '0;
            sec_idx   <= '0;
            if (tf.wdata == OP_FLUSH_EXT)
            begin
              cache_flush_out <= 1'b1; // [R1]
              state           <= S_FLUSH;
            end
            else if (tf.wdata == OP_FORMAT_TRACK)
            begin
              media_lba_out <= track_base; // [R3] [R7]
              if (range_bad)
              begin
                rejected <= 1'b1; // [R12]
                state    <= S_DONE;
              end
              else if (!lba_mode && chs_bad)
              begin
                not_found <= 1'b1;
                state     <= S_DONE;
              end
              else
              begin
                state <= S_TABLE;
              end
            end
            else
            begin
              rejected <= 1'b1;
              state    <= S_DONE;
            end
          end
        end
        S_TABLE:
        begin
          // The table bytes are counted and then dropped unread.
          if (data_wr)
          begin
            table_cnt <= table_cnt + 16'h0001; // [R6]
            if (table_cnt == 16'(TBL_LEN - 1))
            begin
              state <= S_FORMAT;
            end
          end
        end
        S_FLUSH:
        begin
          if (cache_clean_in)
          begin
            cache_flush_out <= 1'b0;
            state           <= S_DONE; // [R2]
          end
        end
        S_FORMAT:
        begin
          // One pass over the track in relative order, skipping
          // sectors marked bad; completion follows the last sector, written or skipped.
          if (sec_idx == 8'(SPT))
          begin
            state <= S_DONE; // [R5]
          end
          else if (sector_good_in)
          begin
            media_write_out <= 1'b1; // [R4]
            state           <= S_WRITE;
          end
          else
          begin
            sec_idx       <= sec_idx + 8'h01;
            media_lba_out <= media_lba_out + 28'h0000001; // [R7]
          end
        end
        S_WRITE:
        begin
          if (media_ack_in)
          begin
            media_write_out <= 1'b0;
            sec_idx         <= sec_idx + 8'h01;
            media_lba_out   <= media_lba_out + 28'h0000001; // [R7]
            state           <= S_FORMAT;
          end
        end
        S_DONE:
        begin
          state <= S_IDLE;
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Status and error registers.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      tf.status <= STATUS_RESET;
      tf.error  <= 8'h00;
    end
    else if (cmd_take)
    begin
      tf.status[ST_OCCUPIED] <= 1'b1;
      tf.status[ST_ERR]      <= 1'b0;
      tf.error               <= 8'h00;
    end
    else if (state == S_TABLE)
    begin
      // Occupied rises with the last table byte, so the host never sees
      // both occupied and DRQ low before the zero fill has run.
      tf.status[ST_OCCUPIED] <= data_wr &&
                                table_cnt == 16'(TBL_LEN - 1);
      tf.status[ST_DRQ]      <= !(data_wr &&
                                  table_cnt == 16'(TBL_LEN - 1));
    end
    else if (state == S_DONE)
    begin
      tf.error[ER_REJECTED]  <= rejected; // [R12]
      tf.error[ER_NOT_FOUND] <= not_found;
      tf.status[ST_ERR]      <= rejected || not_found; // [R13]
      tf.status[ST_OCCUPIED] <= 1'b0; // [R13] [R2]
    end
  end

  // Address registers: written by the host while idle, and in block
  // mode rewritten at completion with the current address.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      tf.sector   <= 8'h00;
      tf.cyl_lo   <= 8'h00;
      tf.cyl_hi   <= 8'h00;
      tf.dev_head <= DEV_HEAD_RESET;
    end
    else if (state == S_DONE && lba_mode)
    begin
      tf.sector        <= lba_req[7:0]; // [R11]
      tf.cyl_lo        <= lba_req[15:8]; // [R11]
      tf.cyl_hi        <= lba_req[23:16]; // [R11]
      tf.dev_head[3:0] <= lba_req[27:24]; // [R11]
    end
    else if (tf.wr && !tf.status[ST_OCCUPIED] && state == S_IDLE)
    begin
      case (tf.sel)
        TF_SECTOR:   tf.sector   <= tf.wdata;
        TF_CYL_LO:   tf.cyl_lo   <= tf.wdata;
        TF_CYL_HI:   tf.cyl_hi   <= tf.wdata;
        TF_DEV_HEAD: tf.dev_head <= tf.wdata;
        default:     tf.sector   <= tf.sector;
      endcase
    end
  end

endmodule : ata_cmd_device

// ===== core/ata_cmd_host.sv
// Host controller that issues task file commands under APB control.
module ata_cmd_host
  import ata_cmd_pkg::*;
#(
  parameter int TBL_LEN = TABLE_BYTES
)
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             irq_out,
  // Task file
  ata_taskfile_if.host     tf
);

  if (TBL_LEN < 1 || TBL_LEN > 65535)
  begin : g_check
    $error("ata_cmd_host: unsupported table length");
  end

  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_LOAD  = 4'b0010,
    H_TABLE = 4'b0100,
    H_WAIT  = 4'b1000
  } host_state_t;

  host_state_t state;
  logic [7:0]  opcode;
  logic [28:0] addr;
  logic [15:0] result;
  logic [27:0] ret_addr;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [2:0]  step;
  logic [15:0] sent;
  logic        wr_hit;
  logic        setup;
  logic        finish;

  function automatic logic mapped(input logic [7:0] a);
    return a == REG_CMD || a == REG_ADDR || a == REG_RESULT ||
           a == REG_RET_ADDR || a == REG_IRQ_STATUS || a == REG_IRQ_MASK;
  endfunction : mapped

  assign setup  = psel_in && !penable_in;
  assign wr_hit = psel_in && penable_in && pready_out && pwrite_in;
  // The command pulse itself is excluded: occupied rises only one cycle
  // after it, so the status seen alongside the pulse is stale.
  assign finish = (state == H_WAIT || state == H_TABLE) && !tf.wr &&
                  !tf.status[ST_OCCUPIED] && !tf.status[ST_DRQ];

  // APB answers in the first access cycle.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end
    else
    begin
      pready_out  <= setup;
      pslverr_out <= setup && !mapped(paddr_in);
      prdata_out  <= 32'h00000000;
      if (setup && !pwrite_in)
      begin
        case (paddr_in)
          REG_CMD:        prdata_out <= {24'h000000, opcode};
          REG_ADDR:       prdata_out <= {3'b000, addr};
          REG_RESULT:     prdata_out <= {15'h0000, state != H_IDLE,
                                         result};
          REG_RET_ADDR:   prdata_out <= {4'h0, ret_addr};
          REG_IRQ_STATUS: prdata_out <= {30'h00000000, irq_status};
          REG_IRQ_MASK:   prdata_out <= {30'h00000000, irq_mask};
          default:        prdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // Software registers; a completion event wins over a clear.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      addr       <= '0;
      irq_mask   <= 2'b00;
      irq_status <= 2'b00;
      irq_out    <= 1'b0;
    end
    else
    begin
      if (wr_hit && paddr_in == REG_ADDR && state == H_IDLE)
      begin
        addr <= pwdata_in[28:0];
      end
      if (wr_hit && paddr_in == REG_IRQ_MASK)
      begin
        irq_mask <= pwdata_in[1:0];
      end
      irq_status <= (irq_status &
                     ~((wr_hit && paddr_in == REG_IRQ_STATUS) ?
                       pwdata_in[1:0] : 2'b00)) |
                    {finish && tf.status[ST_ERR], finish};
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // Command sequencer: loads the address registers, then the command,
  // sends a blank format table when asked, then waits for completion.
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state    <= H_IDLE;
      opcode   <= 8'h00;
      step     <= 3'h0;
      sent     <= '0;
      result   <= '0;
      ret_addr <= '0;
      tf.wr    <= 1'b0;
      tf.sel   <= TF_DATA;
      tf.wdata <= 8'h00;
    end
    else
    begin
      tf.wr <= 1'b0;
      case (state)
        H_IDLE:
        begin
          if (wr_hit && paddr_in == REG_CMD)
          begin
            opcode <= pwdata_in[7:0];
            step   <= 3'h0;
            sent   <= '0;
            state  <= H_LOAD;
          end
        end
        H_LOAD:
        begin
          tf.wr <= 1'b1;
          step  <= step + 3'h1;
          case (step)
            3'h0: {tf.sel, tf.wdata} <= {TF_SECTOR, addr[7:0]}; // [R9]
            3'h1: {tf.sel, tf.wdata} <= {TF_CYL_LO, addr[15:8]}; // [R8]
            3'h2: {tf.sel, tf.wdata} <= {TF_CYL_HI, addr[23:16]}; // [R8]
            3'h3: {tf.sel, tf.wdata} <= {TF_DEV_HEAD, 1'b1,
                                         addr[ADDR_LBA_BIT], 2'b10,
                                         addr[27:24]}; // [R8] [R9]
            default:
            begin
              {tf.sel, tf.wdata} <= {TF_COMMAND, opcode}; // [R1] [R3]
              state <= (opcode == OP_FORMAT_TRACK) ? H_TABLE : H_WAIT;
            end
          endcase
        end
        H_TABLE:
        begin
          if (tf.status[ST_DRQ] && sent != 16'(TBL_LEN))
          begin
            tf.wr    <= 1'b1;
            tf.sel   <= TF_DATA;
            tf.wdata <= 8'h00; // [R6]
            sent     <= sent + 16'h0001;
          end
          else if (sent == 16'(TBL_LEN) || finish)
          begin
            state <= H_WAIT;
          end
        end
        H_WAIT:
        begin
          if (finish)
          begin
            result   <= {tf.error, tf.status};
            ret_addr <= {tf.dev_head[3:0], tf.cyl_hi, tf.cyl_lo,
                         tf.sector};
            state    <= H_IDLE;
          end
        end
        default:
        begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule : ata_cmd_host

// ===== dv/cache_flush_track_format_cmds_asserts.sv
// Interface checks for the flush and track format command path.
module cache_flush_track_format_cmds_asserts
  import ata_cmd_pkg::*;
#(
  parameter int SPT     = SECTORS_PER_TRACK,
  parameter int MAX_LBA = TOTAL_LBA,
  parameter int TBL_LEN = TABLE_BYTES
)
(
  // Clock and reset
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  // Task file
  input wire logic        wr,
  input wire logic [2:0]  sel,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  status,
  input wire logic [7:0]  error,
  input wire logic [7:0]  sector,
  input wire logic [7:0]  cyl_lo,
  input wire logic [7:0]  cyl_hi,
  input wire logic [7:0]  dev_head,
  // Cache and media
  input wire logic        cache_clean_in,
  input wire logic        media_write_out,
  input wire logic [27:0] media_lba_out,
  input wire logic        media_ack_in
);
  logic [27:0] lba;
  logic        lba_mode;
  logic [7:0]  op;
  int          data_cnt;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // Shadow of what the host wrote, so results can be tied to requests.
  always_ff @(posedge ref_clk_in)
    if (rst_in)
    begin
      lba      <= 28'h0000000;
      lba_mode <= 1'b0;
      op       <= 8'h00;
    end
    else if (wr)
    begin
      case (sel)
        TF_SECTOR:   lba[7:0]   <= wdata;
        TF_CYL_LO:   lba[15:8]  <= wdata;
        TF_CYL_HI:   lba[23:16] <= wdata;
        TF_DEV_HEAD: {lba_mode, lba[27:24]} <=
                       {wdata[DH_LBA_MODE], wdata[3:0]};
        TF_COMMAND:  op <= wdata;
        default:     ;
      endcase
    end

  always_ff @(posedge ref_clk_in)
    if (rst_in || !status[ST_DRQ])
      data_cnt <= 0;
    else if (wr && sel == TF_DATA)
      data_cnt <= data_cnt + 1;

  property p_flush_busy;
    wr && sel == TF_COMMAND && wdata == OP_FLUSH_EXT && !status[ST_OCCUPIED]
      |=> status[ST_OCCUPIED];
  endproperty
  a_flush_busy: assert property (p_flush_busy)
    else $error("flush did not raise busy");

  property p_flush_hold;
    status[ST_OCCUPIED] && op == OP_FLUSH_EXT && !cache_clean_in
      |=> status[ST_OCCUPIED];
  endproperty
  a_flush_hold: assert property (p_flush_hold)
    else $error("flush ended before cache was clean");

  property p_tbl_count;
    $fell(status[ST_DRQ]) |-> data_cnt == TBL_LEN && status[ST_OCCUPIED];
  endproperty
  a_tbl_count: assert property (p_tbl_count)
    else $error("format table length wrong");

  property p_media_hold;
    media_write_out && !media_ack_in |=> media_write_out;
  endproperty
  a_media_hold: assert property (p_media_hold)
    else $error("sector write dropped before ack");

  property p_track;
    $rose(media_write_out) && lba_mode |-> media_lba_out / SPT == lba / SPT;
  endproperty
  a_track: assert property (p_track)
    else $error("sector outside requested track");

  property p_reject;
    wr && sel == TF_COMMAND && wdata == OP_FORMAT_TRACK && lba_mode &&
      lba >= MAX_LBA |-> ##[1:20] error[ER_REJECTED] && !status[ST_OCCUPIED];
  endproperty
  a_reject: assert property (p_reject)
    else $error("out of range address not rejected");

  property p_err_sum;
    $fell(status[ST_OCCUPIED]) && !status[ST_DRQ]
      |-> status[ST_ERR] == (error != 8'h00);
  endproperty
  a_err_sum: assert property (p_err_sum)
    else $error("error summary disagrees with error flags");

  property p_readback;
    $fell(status[ST_OCCUPIED]) && !status[ST_DRQ] && lba_mode &&
      op == OP_FORMAT_TRACK && error == 8'h00
      |-> {dev_head[3:0], cyl_hi, cyl_lo, sector} == lba;
  endproperty
  a_readback: assert property (p_readback)
    else $error("block address readback wrong");
endmodule : cache_flush_track_format_cmds_asserts

// ===== dv/cache_flush_track_format_cmds_test.sv
// Self-checking bench for the flush and track format command path.
module cache_flush_track_format_cmds_test
  import ata_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SPT = 8;
  localparam int TBL = 4;
  localparam logic [7:0] REJ = 8'(1 << ER_REJECTED);
  localparam logic [7:0] NF  = 8'(1 << ER_NOT_FOUND);
  logic        ref_clk_in = 1'b0, rst_in = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h62;
  logic        pready, pslverr, irq, se, mask_on;
  logic        cache_flush, cache_clean = 1'b0, media_ack = 1'b0;
  logic        media_write, sector_good;
  logic [27:0] media_lba, track, lba;
  logic [15:0] cyl;
  logic [27:0] corner [4] = '{28'h0, 28'(TOTAL_LBA - 1), 28'(TOTAL_LBA),
                               28'hFFFFFFF};
  int          err_count, samples_checked, writes, exp_writes;

  ata_taskfile_if i_ata_taskfile_if ();
  ata_cmd_device #(.SPT(SPT), .TBL_LEN(TBL)) i_ata_cmd_device (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .tf(i_ata_taskfile_if),
    .cache_flush_out(cache_flush), .cache_clean_in(cache_clean),
    .media_write_out(media_write), .media_lba_out(media_lba),
    .sector_good_in(sector_good), .media_ack_in(media_ack));
  ata_cmd_host #(.TBL_LEN(TBL)) i_ata_cmd_host (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .irq_out(irq), .tf(i_ata_taskfile_if));
  cache_flush_track_format_cmds_asserts #(.SPT(SPT), .TBL_LEN(TBL))
    i_cache_flush_track_format_cmds_asserts (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wr(i_ata_taskfile_if.wr), .sel(i_ata_taskfile_if.sel),
    .wdata(i_ata_taskfile_if.wdata), .status(i_ata_taskfile_if.status),
    .error(i_ata_taskfile_if.error), .sector(i_ata_taskfile_if.sector),
    .cyl_lo(i_ata_taskfile_if.cyl_lo), .cyl_hi(i_ata_taskfile_if.cyl_hi),
    .dev_head(i_ata_taskfile_if.dev_head), .cache_clean_in(cache_clean),
    .media_write_out(media_write), .media_lba_out(media_lba),
    .media_ack_in(media_ack));

  always #5 ref_clk_in = ~ref_clk_in;

  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : next_rand

  // Some sectors are bad so that skipping them is exercised in every track.
  function automatic logic good_of(input logic [27:0] a);
    return (a[2:0] ^ a[5:3]) != 3'h5;
  endfunction : good_of

  function automatic int count_good(input logic [27:0] base);
    int n = 0;
    for (int i = 0; i < SPT; i++)
      n += int'(good_of(base + 28'(i)));
    return n;
  endfunction : count_good

  assign sector_good = good_of(media_lba);

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge ref_clk_in);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      err_count++;
      end_sim();
    end
  endtask : apb

  // Media acks at a random pace; the cache turns clean only while a flush
  // waits and stays clean until busy drops, so no flush ends early.
  always @(posedge ref_clk_in)
  begin
    media_ack <= media_write && !media_ack && next_rand() % 2 == 1;
    if (cache_clean)
      cache_clean <= i_ata_taskfile_if.status[ST_OCCUPIED];
    else
      cache_clean <= cache_flush && next_rand() % 4 == 0;
    if (media_write === 1'b1 && media_ack === 1'b1)
    begin
      writes++;
      chk("written sector good", 1, sector_good);
      if (exp_writes > 0)
        chk("written track", track, media_lba - media_lba % SPT);
    end
  end

  task automatic do_cmd(input string name, input logic [7:0] cmd,
                        input logic [31:0] addr, input logic [7:0] er);
    int n;
    track = addr[ADDR_LBA_BIT] ? 28'(addr[27:0] - addr[27:0] % SPT) :
            28'((addr[23:8] * HEAD_COUNT + addr[27:24]) * SPT);
    exp_writes = cmd != OP_FORMAT_TRACK || er != 0 ? 0 : count_good(track);
    writes = 0;
    apb(1'b1, REG_ADDR, addr);
    apb(1'b1, REG_CMD, {24'h0, cmd});
    for (n = 0; n < 500 && q[IRQ_DONE] !== 1'b1; n++)
      apb(1'b0, REG_IRQ_STATUS, 32'h0);
    if (n == 500)
    begin
      err_count++;
      end_sim();
    end
    chk("irq status", {30'h0, er != 8'h00, 1'b1}, q);
    chk("irq line", mask_on, irq);
    apb(1'b0, REG_RESULT, 32'h0);
    chk("result", {16'h0, er, STATUS_RESET[7:1], er != 8'h00}, q);
    if (exp_writes >= 0)
      chk("zeroed sectors", exp_writes, writes);
    if (exp_writes > 0 && addr[ADDR_LBA_BIT])
    begin
      apb(1'b0, REG_RET_ADDR, 32'h0);
      chk("returned address", addr[27:0], q[27:0]);
    end
    apb(1'b1, REG_IRQ_STATUS, 32'h3);
    apb(1'b0, REG_IRQ_STATUS, 32'h0);
    chk("irq cleared", 0, {q[31:2], q[1:0]});
    chk("irq line low", 0, irq);
    $display("test %s done", name);
  endtask : do_cmd

  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    apb(1'b0, REG_RESULT, 32'h0);
    chk("reset result", 32'h00000000, q);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 1, se);
    chk("unmapped data", 0, q);
    apb(1'b1, REG_IRQ_MASK, 32'h3);
    mask_on = 1'b1;
    do_cmd("flush", OP_FLUSH_EXT, 32'h0, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      lba = i < 4 ? corner[i] : 28'(next_rand() % TOTAL_LBA);
      do_cmd("block format", OP_FORMAT_TRACK, {4'h1, lba},
             lba >= TOTAL_LBA ? REJ : 8'h00);
    end
    for (int i = 0; i < 2; i++)
    begin
      cyl = i == 0 ? 16'(next_rand() % CYL_COUNT) : 16'(CYL_COUNT);
      do_cmd("chs format", OP_FORMAT_TRACK, {4'h0, 4'(next_rand()), cyl,
             8'h00}, i == 0 ? 8'h00 : NF);
    end
    do_cmd("unknown", 8'hC5, 32'h0, REJ);
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    mask_on = 1'b0;
    do_cmd("masked", OP_FORMAT_TRACK, 32'h1FFFFFFF, REJ);
    do_cmd("masked flush", OP_FLUSH_EXT, 32'h0, 8'h00);
    end_sim();
  end
endmodule : cache_flush_track_format_cmds_test
